// >>> common/dcfs_pkg.sv
// Purpose: shared constants for the carrier and fec status register bank
// Assumes: apb, 32-bit data; register index times four is the byte address
// Notes: printed offsets are not all word aligned, so they are kept as indices
package dcfs_pkg;

  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int IDX_W = 8;

  // register indices, byte address = index * 4
  localparam logic [7:0] IDX_LATCH_CTRL = 8'h25;
  localparam logic [7:0] IDX_ACC_LOW = 8'h3c;
  localparam logic [7:0] IDX_ACC_MID = 8'h3d;
  localparam logic [7:0] IDX_ACC_HIGH = 8'h3e;
  localparam logic [7:0] IDX_SYNC_STATE = 8'h41;
  localparam logic [7:0] IDX_SEG_ERR_LOW = 8'h43;
  localparam logic [7:0] IDX_SEG_ERR_HIGH = 8'h44;
  localparam logic [7:0] IDX_INT_STATUS = 8'h70;
  localparam logic [7:0] IDX_INT_MASK = 8'h71;

  // value widths
  localparam int ACC_W = 20;
  localparam int SEG_ERR_W = 12;
  localparam int FEC_W = 2;
  localparam int TRELLIS_W = 2;
  localparam int DEINT_W = 4;
  localparam int SNAP_W = ACC_W + SEG_ERR_W + FEC_W + TRELLIS_W + DEINT_W;

  // snapshot vector layout
  localparam int SNAP_SEG_LSB = 0;
  localparam int SNAP_FEC_LSB = SNAP_SEG_LSB + SEG_ERR_W;
  localparam int SNAP_DEINT_LSB = SNAP_FEC_LSB + FEC_W;
  localparam int SNAP_TRELLIS_LSB = SNAP_DEINT_LSB + DEINT_W;
  localparam int SNAP_ACC_LSB = SNAP_TRELLIS_LSB + TRELLIS_W;

  // field positions
  localparam int LATCH_GO_BIT = 0;
  localparam int SEG_HIGH_LSB = 4;

  // fec synchronizer codes
  localparam logic [1:0] FEC_SEARCHING = 2'h0;
  localparam logic [1:0] FEC_LOCKED = 2'h1;
  localparam logic [1:0] FEC_LOST = 2'h3;

  // trellis sync codes
  localparam logic [1:0] TRELLIS_LOCK_LOW_ERR = 2'h0;
  localparam logic [1:0] TRELLIS_LOCK_HIGH_ERR = 2'h2;
  localparam logic [1:0] TRELLIS_HUNTING = 2'h3;

  // interrupt status bits
  localparam int INT_W = 3;
  localparam int INT_SNAP_BIT = 0;
  localparam int INT_FEC_LOST_BIT = 1;
  localparam int INT_TRELLIS_HUNT_BIT = 2;

  // reset values
  localparam logic [SNAP_W-1:0] SNAP_RESET = '0;
  localparam logic [INT_W-1:0] INT_MASK_RESET = 3'h0;
  localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000;

  typedef enum logic [1:0] {
    DCFS_PH_IDLE = 2'b00,
    DCFS_PH_SETUP = 2'b01,
    DCFS_PH_ACCESS = 2'b10
  } dcfs_phase_t;

endpackage : dcfs_pkg

// >>> design/dcfs_snapshot.sv
// Purpose: holds one coherent copy of all live status values
// Assumes: capture is a single-cycle pulse in the pclk domain
// Notes: every bit loads on the same edge, so multi-byte reads agree
`timescale 1ns/100ps
module dcfs_snapshot #(
  parameter int WIDTH = dcfs_pkg::SNAP_W
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic capture,
  input wire logic [WIDTH-1:0] live,
  output logic [WIDTH-1:0] held
);

  logic [WIDTH-1:0] held_r;
  logic [WIDTH-1:0] held_nxt;

  always_comb begin
    held_nxt = held_r;
    if (capture) begin
      held_nxt = live;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      held_r <= '0;
    end else begin
      held_r <= held_nxt;
    end
  end

  assign held = held_r;

endmodule : dcfs_snapshot

// >>> design/dcfs_status_regs.sv
// Purpose: apb status bank for carrier loop, fec sync and segment errors
// Assumes: live inputs are synchronous to pclk; zero wait state slave
// Notes: held values change only on a latch command, or at 41h on a qam_mode switch; 70h bits set on latch, live fec lost and qam trellis hunt events
//
// Operation
// - 20-bit carrier accumulator split over 3Ch, 3Dh and low nibble of 3Eh.
// - snapshot refreshes only when host writes one to bit 0 at 25h.
// - unused upper bits read zero: 3Eh bits 7:4, 41h bits 7:2 in vsb.
// - vsb 41h bits 1:0 hold fec sync: 00 search, 11 lost, 10 unused.
// - fec sync code 01 means locked, data valid, in both modes.
// - qam 41h bits 7:6 trellis: 00 lock low err, 10 lock high, 11 hunt.
// - qam 41h bits 5:2 hold latched deinterleaver control value.
// - 12-bit segment error count: 43h bits 7:0, 44h bits 7:4.
//
// Local design decision: register access over APB.
`timescale 1ns/100ps
module dcfs_status_regs #(
  parameter int ADDR_W = dcfs_pkg::ADDR_W
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic qam_mode,
  input wire logic [19:0] carrier_acc_live,
  input wire logic [1:0] fec_sync_live,
  input wire logic [1:0] trellis_sync_live,
  input wire logic [3:0] deint_ctrl_live,
  input wire logic [11:0] seg_err_count_live,
  output logic irq
);

  // register index of an address, word aligned
  function automatic logic [7:0] reg_index(input logic [ADDR_W-1:0] a);
    reg_index = a[dcfs_pkg::IDX_W+1:2];
  endfunction : reg_index

  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    logic [7:0] idx;
    idx = a[dcfs_pkg::IDX_W+1:2];
    is_mapped = 1'b0;
    if ((a[1:0] == 2'b00) && (a[ADDR_W-1:dcfs_pkg::IDX_W+2] == '0)) begin
      case (idx)
        dcfs_pkg::IDX_LATCH_CTRL,
        dcfs_pkg::IDX_ACC_LOW,
        dcfs_pkg::IDX_ACC_MID,
        dcfs_pkg::IDX_ACC_HIGH,
        dcfs_pkg::IDX_SYNC_STATE,
        dcfs_pkg::IDX_SEG_ERR_LOW,
        dcfs_pkg::IDX_SEG_ERR_HIGH,
        dcfs_pkg::IDX_INT_STATUS,
        dcfs_pkg::IDX_INT_MASK: is_mapped = 1'b1;
        default: is_mapped = 1'b0;
      endcase
    end
  endfunction : is_mapped

  // bus phase tracking
  dcfs_pkg::dcfs_phase_t phase_r;
  dcfs_pkg::dcfs_phase_t phase_nxt;
  logic setup_cyc;
  logic access_cyc;
  logic wr_done;
  logic rd_done;
  logic [7:0] acc_idx;

  assign setup_cyc = psel && !penable;
  assign access_cyc = psel && penable;
  assign acc_idx = reg_index(paddr);
  // zero wait: every access completes in its first access cycle
  assign pready = 1'b1;
  assign pslverr = access_cyc && !is_mapped(paddr);
  assign wr_done = access_cyc && pwrite && is_mapped(paddr);
  assign rd_done = access_cyc && !pwrite && is_mapped(paddr);

  always_comb begin
    case (phase_r)
      dcfs_pkg::DCFS_PH_IDLE: begin
        phase_nxt = setup_cyc ? dcfs_pkg::DCFS_PH_SETUP
                              : dcfs_pkg::DCFS_PH_IDLE;
      end
      dcfs_pkg::DCFS_PH_SETUP: begin
        phase_nxt = access_cyc ? dcfs_pkg::DCFS_PH_ACCESS
                               : dcfs_pkg::DCFS_PH_IDLE;
      end
      dcfs_pkg::DCFS_PH_ACCESS: begin
        phase_nxt = setup_cyc ? dcfs_pkg::DCFS_PH_SETUP
                              : dcfs_pkg::DCFS_PH_IDLE;
      end
      default: phase_nxt = dcfs_pkg::DCFS_PH_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_r <= dcfs_pkg::DCFS_PH_IDLE;
    end else begin
      phase_r <= phase_nxt;
    end
  end

  // latch command: only a write of one to bit 0 at 25h refreshes
  logic latch_go;
  assign latch_go = wr_done && (acc_idx == dcfs_pkg::IDX_LATCH_CTRL) &&
                    pstrb[0] && pwdata[dcfs_pkg::LATCH_GO_BIT];

  // all values captured together on one edge
  logic [dcfs_pkg::SNAP_W-1:0] snap_live;
  logic [dcfs_pkg::SNAP_W-1:0] snap_held;

  assign snap_live = {carrier_acc_live, trellis_sync_live, deint_ctrl_live,
                      fec_sync_live, seg_err_count_live};

  dcfs_snapshot #(
    .WIDTH(dcfs_pkg::SNAP_W)
  ) u_snapshot (
    .pclk(pclk),
    .presetn(presetn),
    .capture(latch_go),
    .live(snap_live),
    .held(snap_held)
  );

  logic [19:0] acc_s;
  logic [1:0] trellis_s;
  logic [3:0] deint_s;
  logic [1:0] fec_s;
  logic [11:0] seg_s;

  assign acc_s = snap_held[dcfs_pkg::SNAP_ACC_LSB +: dcfs_pkg::ACC_W];
  assign trellis_s =
    snap_held[dcfs_pkg::SNAP_TRELLIS_LSB +: dcfs_pkg::TRELLIS_W];
  assign deint_s = snap_held[dcfs_pkg::SNAP_DEINT_LSB +: dcfs_pkg::DEINT_W];
  assign fec_s = snap_held[dcfs_pkg::SNAP_FEC_LSB +: dcfs_pkg::FEC_W];
  assign seg_s = snap_held[dcfs_pkg::SNAP_SEG_LSB +: dcfs_pkg::SEG_ERR_W];

  // sync state byte; mode is read live so a mode switch shows at once
  logic [7:0] sync_byte;
  always_comb begin
    if (qam_mode) begin
      sync_byte = {trellis_s, deint_s, fec_s};
    end else begin
      sync_byte = {6'h00, fec_s};
    end
  end

  // event detection on live values
  logic [1:0] fec_prev_r;
  logic [1:0] fec_prev_nxt;
  logic [1:0] trellis_prev_r;
  logic [1:0] trellis_prev_nxt;
  logic [dcfs_pkg::INT_W-1:0] int_event;

  assign fec_prev_nxt = fec_sync_live;
  assign trellis_prev_nxt = trellis_sync_live;

  always_comb begin
    int_event = '0;
    int_event[dcfs_pkg::INT_SNAP_BIT] = latch_go;
    int_event[dcfs_pkg::INT_FEC_LOST_BIT] =
      (fec_sync_live == dcfs_pkg::FEC_LOST) &&
      (fec_prev_r != dcfs_pkg::FEC_LOST);
    int_event[dcfs_pkg::INT_TRELLIS_HUNT_BIT] = qam_mode &&
      (trellis_sync_live == dcfs_pkg::TRELLIS_HUNTING) &&
      (trellis_prev_r != dcfs_pkg::TRELLIS_HUNTING);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fec_prev_r <= dcfs_pkg::FEC_SEARCHING;
      trellis_prev_r <= dcfs_pkg::TRELLIS_HUNTING;
    end else begin
      fec_prev_r <= fec_prev_nxt;
      trellis_prev_r <= trellis_prev_nxt;
    end
  end

  // interrupt status and mask
  logic [dcfs_pkg::INT_W-1:0] int_stat_r;
  logic [dcfs_pkg::INT_W-1:0] int_stat_nxt;
  logic [dcfs_pkg::INT_W-1:0] int_mask_r;
  logic [dcfs_pkg::INT_W-1:0] int_mask_nxt;
  logic stat_clear;

  assign stat_clear = rd_done && (acc_idx == dcfs_pkg::IDX_INT_STATUS);

  always_comb begin
    int_stat_nxt = int_stat_r;
    if (stat_clear) begin
      int_stat_nxt = '0;
    end
    // set after clear so an event in the clearing cycle survives
    int_stat_nxt = int_stat_nxt | int_event;
    int_mask_nxt = int_mask_r;
    if (wr_done && (acc_idx == dcfs_pkg::IDX_INT_MASK) && pstrb[0]) begin
      int_mask_nxt = pwdata[dcfs_pkg::INT_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_stat_r <= '0;
      int_mask_r <= dcfs_pkg::INT_MASK_RESET;
    end else begin
      int_stat_r <= int_stat_nxt;
      int_mask_r <= int_mask_nxt;
    end
  end

  assign irq = |(int_stat_r & int_mask_r);

  // read data, prepared in the setup cycle and held through access
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic [7:0] setup_byte;
  logic [7:0] rd_idx;

  assign rd_idx = reg_index(paddr);

  always_comb begin
    setup_byte = 8'h00;
    case (rd_idx)
      dcfs_pkg::IDX_ACC_LOW: setup_byte = acc_s[7:0];
      dcfs_pkg::IDX_ACC_MID: setup_byte = acc_s[15:8];
      dcfs_pkg::IDX_ACC_HIGH: setup_byte = {4'h0, acc_s[19:16]};
      dcfs_pkg::IDX_SYNC_STATE: setup_byte = sync_byte;
      dcfs_pkg::IDX_SEG_ERR_LOW: setup_byte = seg_s[7:0];
      dcfs_pkg::IDX_SEG_ERR_HIGH: setup_byte = {seg_s[11:8], 4'h0};
      dcfs_pkg::IDX_INT_STATUS: setup_byte = {5'h00, int_stat_r};
      dcfs_pkg::IDX_INT_MASK: setup_byte = {5'h00, int_mask_r};
      default: setup_byte = 8'h00;
    endcase
    rdata_nxt = rdata_r;
    if (setup_cyc && !pwrite) begin
      if (is_mapped(paddr)) begin
        rdata_nxt = {24'h00_0000, setup_byte};
      end else begin
        rdata_nxt = dcfs_pkg::DATA_ZERO;
      end
    end
  end

  // writes to status indices fall through: no state is touched
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_r <= dcfs_pkg::DATA_ZERO;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign prdata = rdata_r;

endmodule : dcfs_status_regs

// >>> bench/dcfs_status_regs_monitor.sv
// Purpose: apb-side assertions for the status bank
// Assumes: zero wait state, byte address is index times four
// Notes: 0fch is an unmapped hole between bank entries
`timescale 1ns/100ps
module dcfs_status_regs_monitor #(
  parameter int ADDR_W = 12
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic qam_mode,
  input wire logic irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire acs = psel && penable;
  wire rd = acs && !pwrite;
  property p_lo; rd && paddr == 'h0F0 |-> prdata < 32'h0000_0100; endproperty
  a_lo: assert property (p_lo) else $error("acc low wide");
  property p_hi; rd && paddr == 'h0F8 |-> prdata < 32'h0000_0010; endproperty
  a_hi: assert property (p_hi) else $error("acc top bits");
  property p_seg;
    rd && paddr == 'h110 |-> prdata[3:0] == 4'h0 && prdata < 32'h0000_0100;
  endproperty
  a_seg: assert property (p_seg) else $error("seg high layout");
  property p_vsb;
    rd && paddr == 'h104 && !qam_mode |-> prdata < 32'h0000_0004;
  endproperty
  a_vsb: assert property (p_vsb) else $error("vsb sync bits");
  property p_qam;
    rd && paddr == 'h104 && qam_mode |-> prdata < 32'h0000_0100
      && prdata[7:6] != 2'h1 && prdata[1:0] != 2'h2;
  endproperty
  a_qam: assert property (p_qam) else $error("qam sync codes");
  // read data must not drift between reads
  property p_hold; !(psel && !penable && !pwrite) |=> $stable(prdata);
  endproperty
  a_hold: assert property (p_hold) else $error("prdata moved");
  property p_ro; acs && pwrite && paddr == 'h0F0 |-> !pslverr; endproperty
  a_ro: assert property (p_ro) else $error("ro write error");
  property p_unm; acs && paddr == 'h0FC |-> pslverr && prdata == 0;
  endproperty
  a_unm: assert property (p_unm) else $error("unmapped ok");
  c_qam: cover property (rd && qam_mode);
  c_vsb: cover property (rd && !qam_mode);
  c_irq: cover property ($rose(irq));
endmodule : dcfs_status_regs_monitor
bind dcfs_status_regs dcfs_status_regs_monitor #(.ADDR_W(ADDR_W)) u_mon (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .qam_mode(qam_mode), .irq(irq));

// >>> bench/dcfs_status_regs_tb.sv
// Purpose: self-checking bench for the status bank
// Assumes: zero wait state apb, single pclk domain
// Notes: live values move after each latch to catch a leaky snapshot
`timescale 1ns/100ps
module dcfs_status_regs_tb;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic [3:0] strb = 4'h1;
  logic pready, pslverr, irq, qam_mode = 0;
  logic [19:0] acc_l = '0, acc_s;
  logic [1:0] fec_l = '0, tr_l = 2'h3, fec_s, tr_s;
  logic [3:0] de_l = '0, de_s;
  logic [11:0] seg_l = '0, seg_s;
  logic [63:0] q[$];
  logic [63:0] e;
  logic [1:0] fec_tab[3] = '{2'h0, 2'h1, 2'h3};
  logic [1:0] tr_tab[3] = '{2'h0, 2'h2, 2'h3};
  localparam logic [31:0] ALL = 32'hFFFF_FFFF;
  int n_fail = 0, checks = 0, cyc = 0, seed = 54476;
  always #50 pclk = ~pclk;
  dcfs_status_regs i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(strb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .qam_mode(qam_mode), .carrier_acc_live(acc_l), .fec_sync_live(fec_l),
    .trellis_sync_live(tr_l), .deint_ctrl_live(de_l),
    .seg_err_count_live(seg_l), .irq(irq));
  task end_of_test;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_of_test
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // master waits on pready, never on a fixed count
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task rd(input logic [11:0] a, input logic [31:0] x, input logic [31:0] m);
    q.push_back({x, m});
    apb(1'b0, a, '0);
  endtask : rd
  always @(posedge pclk) begin
    cyc++;
    if (psel && penable && pready === 1'b1) begin
      chk(pslverr, paddr == 12'h0FC);
    end
    if (psel && penable && pready === 1'b1 && !pwrite && q.size() > 0) begin
      e = q.pop_front();
      chk(prdata & e[31:0], e[63:32]);
    end
    if (cyc == 3000) begin
      n_fail++;
      end_of_test();
    end
  end
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd(12'h1C4, 32'h0000_0000, ALL);
    apb(1'b1, 12'h1C4, 32'h0000_0001);
    for (int i = 0; i < 9; i++) begin
      @(posedge pclk);
      qam_mode <= i[0];
      acc_l <= $random(seed);
      seg_l <= $random(seed);
      de_l <= $random(seed);
      fec_l <= fec_tab[i % 3];
      tr_l <= tr_tab[(i / 3) % 3];
      apb(1'b1, 12'h094, 32'h0000_0001);
      {acc_s, seg_s, de_s, fec_s, tr_s} = {acc_l, seg_l, de_l, fec_l, tr_l};
      @(posedge pclk);
      chk(irq, 1'b1);
      acc_l <= $random(seed);
      seg_l <= $random(seed);
      de_l <= $random(seed);
      // bit 0 clear must not refresh; ro write must not land
      apb(1'b1, 12'h094, 32'hFFFF_FFFE);
      // lane 0 disabled: a set bit 0 must not refresh either
      strb <= 4'h0;
      apb(1'b1, 12'h094, 32'h0000_0001);
      strb <= 4'h1;
      apb(1'b1, 12'h0F0, $random(seed));
      rd(12'h0F0, acc_s[7:0], ALL);
      rd(12'h0F4, acc_s[15:8], ALL);
      rd(12'h0F8, acc_s[19:16], ALL);
      rd(12'h104, i[0] ? {tr_s, de_s, fec_s} : fec_s, ALL);
      rd(12'h10C, seg_s[7:0], ALL);
      rd(12'h110, {seg_s[11:8], 4'h0}, ALL);
      rd(12'h1C0, 32'h0000_0001, 32'h0000_0001);
      @(posedge pclk);
      chk(irq, 1'b0);
      rd(12'h0FC, 32'h0000_0000, ALL);
    end
    end_of_test();
  end
endmodule : dcfs_status_regs_tb
